// file: hw/scan_line_port.sv
`timescale 1ns/100ps
module scan_line_port
(
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       arst_n_in,
    // Internal register port
    input  wire logic [7:0]                 reg_addr_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    input  wire logic [7:0]                 reg_wdata_in,
    output logic      [7:0]                 reg_rdata_out,
    output logic                            seq_busy_out,
    // Control bits held in the control and status register
    input  wire logic                       scan_port_enable_in,
    input  wire logic                       scan_reset_n_in,
    // Scan port pins
    output scan_port_pkg::scan_lines_t      scan_lines_out,
    output logic                            scan_lines_oe_out,
    output logic                            scan_reset_n_out,
    output logic                            scan_reset_n_oe_out,
    input  wire logic                       tdo_in
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    scan_port_pkg::scan_lines_t lines_q;
    scan_port_pkg::scan_lines_t lines_cmd_d;
    scan_port_pkg::seq_state_t  seq_q;
    logic [1:0]                 auto_data_q;
    logic                       tdo_sync;
    logic                       line_wr;
    logic                       cmd_accept;
    logic                       auto_start;
    logic [2:0]                 lines_vec;
    logic [2:0]                 cmd_vec;
    logic [7:0]                 rdata_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    // TDO comes from another board, so it is resynchronised
    scan_sync2 scan_sync2_inst
    (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .async_in  (tdo_in),
        .sync_out  (tdo_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode

    assign line_wr      = reg_wr_in && (reg_addr_in == scan_port_pkg::LINE_CTRL_OFFSET);
    // Writes are dropped while disabled or while a sequence runs
    assign cmd_accept   = line_wr && scan_port_enable_in && (seq_q == scan_port_pkg::SEQ_IDLE);
    // All six command bits high selects the automatic sequence
    assign auto_start   = cmd_accept && (reg_wdata_in[5:0] == scan_port_pkg::AUTO_TRIGGER);
    assign seq_busy_out = (seq_q != scan_port_pkg::SEQ_IDLE);

    assign lines_vec = lines_q;

    // One two-bit command field per line: TCK, TMS, TDI in that order
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_line_cmd
            logic [1:0] field;
            assign field = reg_wdata_in[2*gi+1:2*gi];
            // 01 clears, 10 sets, the two other codes keep the line
            assign cmd_vec[gi] = (field == scan_port_pkg::CMD_CLEAR) ? 1'b0 :
                                 (field == scan_port_pkg::CMD_SET)   ? 1'b1 :
                                 lines_vec[gi];
        end
    endgenerate

    assign lines_cmd_d = cmd_vec;

    ////////////////////////////////////////////////////////////////////////////////
    // Automatic clock sequence

    // One state per system clock cycle of the four-cycle sequence
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            seq_q <= scan_port_pkg::SEQ_IDLE;
        end
        else
        begin
            case (seq_q)
                scan_port_pkg::SEQ_IDLE:
                begin
                    if (auto_start)
                    begin
                        seq_q <= scan_port_pkg::SEQ_LOW;
                    end
                end
                scan_port_pkg::SEQ_LOW:   seq_q <= scan_port_pkg::SEQ_DATA;
                scan_port_pkg::SEQ_DATA:  seq_q <= scan_port_pkg::SEQ_HIGH1;
                scan_port_pkg::SEQ_HIGH1: seq_q <= scan_port_pkg::SEQ_HIGH2;
                scan_port_pkg::SEQ_HIGH2: seq_q <= scan_port_pkg::SEQ_IDLE;
                default:                  seq_q <= scan_port_pkg::SEQ_IDLE;
            endcase
        end
    end

    // TMS and TDI levels of the sequence are captured with the triggering write
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            auto_data_q <= 2'h0;
        end
        else if (auto_start)
        begin
            auto_data_q <= {reg_wdata_in[scan_port_pkg::AUTO_TDI_BIT],
                            reg_wdata_in[scan_port_pkg::AUTO_TMS_BIT]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Scan line registers

    // Lines move only on an accepted write or a running sequence
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            lines_q.tck <= scan_port_pkg::TCK_RESET;
            lines_q.tms <= scan_port_pkg::TMS_RESET;
            lines_q.tdi <= scan_port_pkg::TDI_RESET;
        end
        else
        begin
            case (seq_q)
                scan_port_pkg::SEQ_IDLE:
                begin
                    if (auto_start)
                    begin
                        // Cycle one of the sequence drops TCK
                        lines_q.tck <= 1'b0;
                    end
                    else if (cmd_accept)
                    begin
                        lines_q <= lines_cmd_d;
                    end
                end
                scan_port_pkg::SEQ_LOW:
                begin
                    // Data is presented in cycle two, while TCK is still low
                    lines_q.tms <= auto_data_q[0];
                    lines_q.tdi <= auto_data_q[1];
                end
                scan_port_pkg::SEQ_DATA:
                begin
                    lines_q.tck <= 1'b1;
                end
                scan_port_pkg::SEQ_HIGH2:
                begin
                    lines_q.tck <= 1'b0;
                end
                default:
                begin
                    lines_q <= lines_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive

    assign scan_lines_out = lines_q;
    // Lines float while the port is disabled so another master may own the chain
    assign scan_lines_oe_out   = scan_port_enable_in;
    assign scan_reset_n_out    = scan_reset_n_in;
    assign scan_reset_n_oe_out = scan_port_enable_in;

    ////////////////////////////////////////////////////////////////////////////////
    // Read back

    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd_in && (reg_addr_in == scan_port_pkg::LINE_CTRL_OFFSET))
        begin
            // Live line levels, upper nibble reads zero
            rdata_d[scan_port_pkg::RD_TCK_BIT] = lines_q.tck;
            rdata_d[scan_port_pkg::RD_TMS_BIT] = lines_q.tms;
            rdata_d[scan_port_pkg::RD_TDI_BIT] = lines_q.tdi;
            rdata_d[scan_port_pkg::RD_TDO_BIT] = tdo_sync;
        end
    end

    // Read data is registered; it holds until the next read strobe
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (reg_rd_in)
        begin
            reg_rdata_out <= rdata_d;
        end
    end

endmodule

// file: hw/scan_port_pkg.sv
package scan_port_pkg;

    // Register map of the internal register port
    localparam logic [7:0] LINE_CTRL_OFFSET = 8'h04;

    // Write command field positions inside scan_line_control
    localparam int         TCK_FIELD_LSB    = 0;
    localparam int         TMS_FIELD_LSB    = 2;
    localparam int         TDI_FIELD_LSB    = 4;
    localparam int         AUTO_TMS_BIT     = 6;
    localparam int         AUTO_TDI_BIT     = 7;
    localparam logic [5:0] AUTO_TRIGGER     = 6'h3F;

    // Read bit positions inside scan_line_control
    localparam int         RD_TCK_BIT       = 0;
    localparam int         RD_TMS_BIT       = 1;
    localparam int         RD_TDI_BIT       = 2;
    localparam int         RD_TDO_BIT       = 3;

    // Two-bit command encodings; 00 and 11 do nothing
    localparam logic [1:0] CMD_CLEAR        = 2'h1;
    localparam logic [1:0] CMD_SET          = 2'h2;

    // Reset levels of the scan outputs
    localparam logic       TCK_RESET        = 1'h0;
    localparam logic       TMS_RESET        = 1'h1;
    localparam logic       TDI_RESET        = 1'h0;

    // Automatic sequence length in system clock cycles
    localparam int         SEQ_CYCLES       = 4;

    // Driven scan lines, indexed 0 = TCK, 1 = TMS, 2 = TDI
    typedef struct packed {
        logic tdi;
        logic tms;
        logic tck;
    } scan_lines_t;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'h0,
        SEQ_LOW   = 3'h1,
        SEQ_DATA  = 3'h2,
        SEQ_HIGH1 = 3'h3,
        SEQ_HIGH2 = 3'h4
    } seq_state_t;

endpackage

// file: hw/scan_sync2.sv
`timescale 1ns/100ps
module scan_sync2
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    // Asynchronous level in, synchronised level out
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// file: bench/scan_line_port_asserts.sv
`timescale 1ns/100ps
module scan_line_port_asserts
(
    // Watched ports
    input wire logic                       clk_in,
    input wire logic                       arst_n_in,
    input wire logic [7:0]                 reg_addr_in,
    input wire logic                       reg_wr_in,
    input wire logic                       reg_rd_in,
    input wire logic [7:0]                 reg_wdata_in,
    input wire logic [7:0]                 reg_rdata_out,
    input wire logic                       seq_busy_out,
    input wire logic                       scan_port_enable_in,
    input wire logic                       scan_reset_n_in,
    input wire scan_port_pkg::scan_lines_t scan_lines_out,
    input wire logic                       scan_lines_oe_out,
    input wire logic                       scan_reset_n_out,
    input wire logic                       scan_reset_n_oe_out
);
    logic acc;
    logic aut;
    scan_port_pkg::scan_lines_t ln;
    assign ln = scan_lines_out;
    assign aut = reg_wdata_in[5:0] == scan_port_pkg::AUTO_TRIGGER;
    assign acc = reg_wr_in && scan_port_enable_in && !seq_busy_out
                 && reg_addr_in == scan_port_pkg::LINE_CTRL_OFFSET;
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    AST_OE_FOLLOWS: assert property (scan_lines_oe_out == scan_port_enable_in
        && scan_reset_n_oe_out == scan_port_enable_in) else $error("oe mismatch");
    AST_SRST_PASS: assert property (scan_reset_n_out == scan_reset_n_in)
        else $error("scan reset mismatch");
    AST_READ_BACK: assert property (reg_rd_in
        && reg_addr_in == scan_port_pkg::LINE_CTRL_OFFSET |=> reg_rdata_out[7:4] == 4'h0
        && reg_rdata_out[2:0] == $past(ln)) else $error("readback");
    AST_QUIET: assert property (!acc && !seq_busy_out |=> $stable(ln))
        else $error("lines moved");
    AST_SET_TCK: assert property (acc && !aut && reg_wdata_in[1:0] == 2'h2 |=> ln.tck)
        else $error("tck set");
    AST_CLR_TDI: assert property (acc && !aut && reg_wdata_in[5:4] == 2'h1 |=> !ln.tdi)
        else $error("tdi clear");
    AST_KEEP_TMS: assert property (acc && !aut && reg_wdata_in[3] == reg_wdata_in[2]
        |=> ln.tms == $past(ln.tms)) else $error("tms moved");
    AST_AUTO_SEQ: assert property (acc && aut |=> !ln.tck && seq_busy_out ##1
        !ln.tck && ln.tms == $past(reg_wdata_in[6], 2) && ln.tdi == $past(reg_wdata_in[7], 2)
        ##1 ln.tck [*2] ##1 !ln.tck && !seq_busy_out) else $error("auto sequence");
    AST_BUSY_LEN: assert property ($rose(seq_busy_out) |-> seq_busy_out [*4]
        ##1 !seq_busy_out) else $error("busy length");
    AST_RESET_LEVELS: assert property (disable iff (1'h0) !arst_n_in |-> ln == 3'h2)
        else $error("reset levels");
endmodule
bind scan_line_port scan_line_port_asserts scan_line_port_asserts_inst (.clk_in, .arst_n_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .seq_busy_out,
    .scan_port_enable_in, .scan_reset_n_in, .scan_lines_out, .scan_lines_oe_out,
    .scan_reset_n_out, .scan_reset_n_oe_out);

// file: bench/scan_tap_model.sv
`timescale 1ns/100ps
module scan_tap_model
(
    // Lines from the port
    input  wire scan_port_pkg::scan_lines_t lines_in,
    input  wire logic                       oe_in,
    // Back to the port
    output logic                            tdo_out,
    output logic                            tap_reset_out
);
    logic cap_q;
    int   hi_cnt;
    initial
    begin
        cap_q = 1'h0;
        hi_cnt = 0;
        tdo_out = 1'h0;
    end
    always @(posedge lines_in.tck)
    begin
        cap_q <= lines_in.tdi;
        hi_cnt <= lines_in.tms ? hi_cnt + 1 : 0;
    end
    assign tap_reset_out = hi_cnt > 4;
    // Undriven port: show the inverse so a stale level cannot pass
    always @(negedge lines_in.tck or negedge oe_in)
        tdo_out <= oe_in ? cap_q : ~tdo_out;
endmodule

// file: bench/scan_line_port_bench.sv
`timescale 1ns/100ps
module scan_line_port_bench;
    logic clk_in, arst_n_in, wr, rd, en, srst, tdo, tap_rst;
    logic busy, oe, srst_o, srst_oe;
    logic [7:0] ad, wd, rdat, rv;
    scan_port_pkg::scan_lines_t ln;
    int err_total, samples_checked, cyc;
    scan_line_port scan_line_port_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .reg_addr_in(ad), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd),
        .reg_rdata_out(rdat), .seq_busy_out(busy), .scan_port_enable_in(en),
        .scan_reset_n_in(srst), .scan_lines_out(ln), .scan_lines_oe_out(oe),
        .scan_reset_n_out(srst_o), .scan_reset_n_oe_out(srst_oe), .tdo_in(tdo));
    scan_tap_model scan_tap_model_inst (.lines_in(ln),
        .oe_in(oe), .tdo_out(tdo), .tap_reset_out(tap_rst));
    ////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrt(logic [7:0] a, logic [7:0] d);
        @(posedge clk_in);
        {wr, ad, wd} <= {1'h1, a, d};
        @(posedge clk_in);
        wr <= 1'h0;
        #1;
    endtask
    task automatic rdr(logic [7:0] a);
        @(posedge clk_in);
        {rd, ad} <= {1'h1, a};
        @(posedge clk_in);
        rd <= 1'h0;
        #1 rv = rdat;
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_cmds();
        logic [2:0] e;
        e = 3'h2;
        for (int f = 0; f < 3; f++)
            for (int c = 0; c < 4; c++)
            begin
                wrt(8'h04, 8'(c << 2 * f));
                if (c == 1) e[f] = 1'h0;
                if (c == 2) e[f] = 1'h1;
                chk("lines", 8'(ln), 8'(e));
                rdr(8'h04);
                chk("read", rv & 8'hF7, 8'(e));
            end
    endtask
    task automatic t_reset();
        // Mid-run reset from all lines high: reset levels must come back at once
        @(posedge clk_in);
        arst_n_in <= 1'h0;
        #1 chk("reset lines", 8'(ln), 8'h02);
        chk("reset read data", rdat, 8'h00);
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'h1;
        rdr(8'h04);
        chk("read after reset", rv & 8'hF7, 8'h02);
    endtask
    task automatic t_auto();
        for (int v = 0; v < 4; v++)
        begin
            wrt(8'h04, {v[1:0], 6'h3F});
            chk("s1", 8'({busy, ln.tck}), 8'h02);
            @(posedge clk_in);
            {wr, wd} <= {1'h1, 8'h0A};
            #1 chk("s2", 8'(ln), 8'({v[1:0], 1'h0}));
            @(posedge clk_in);
            wr <= 1'h0;
            #1 chk("s3", 8'(ln.tck), 8'h01);
            @(posedge clk_in);
            #1 chk("s4", 8'(ln.tck), 8'h01);
            @(posedge clk_in);
            #1 chk("s5", 8'({busy, ln}), 8'({v[1:0], 1'h0}));
        end
    endtask
    task automatic t_refuse();
        @(posedge clk_in);
        {en, srst} <= 2'h0;
        wrt(8'h04, 8'h15);
        chk("off", 8'({oe, ln}), 8'h06);
        chk("scan reset off", 8'({srst_oe, srst_o}), 8'h00);
        @(posedge clk_in);
        {en, srst} <= 2'h3;
        wrt(8'h08, 8'h15);
        chk("unmapped", 8'(ln), 8'h06);
        chk("scan reset on", 8'({srst_oe, srst_o}), 8'h03);
        rdr(8'h08);
        chk("unmapped read", rv, 8'h00);
    endtask
    task automatic t_tap();
        // One pulse with TMS low first, so earlier scenarios leave no count behind
        wrt(8'h04, 8'h04);
        wrt(8'h04, 8'h02);
        wrt(8'h04, 8'h01);
        wrt(8'h04, 8'h08);
        // Eight-cycle spacing gives an 800 ns scan clock
        for (int p = 1; p <= 5; p++)
        begin
            wrt(8'h04, 8'h02);
            repeat (2) @(posedge clk_in);
            wrt(8'h04, 8'h01);
            repeat (2) @(posedge clk_in);
            chk("tap reset", 8'(tap_rst), 8'(p > 4));
        end
        for (int b = 1; b >= 0; b--)
        begin
            wrt(8'h04, {b[0], 7'h3F});
            repeat (7) @(posedge clk_in);
            rdr(8'h04);
            chk("tdo", 8'(rv[3]), 8'(b[0]));
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        clk_in = 1'h0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            test_done();
        end
    end
    initial
    begin
        {arst_n_in, wr, rd, ad, wd, en, srst} = {3'h4, 16'h0000, 2'h3};
        // A clean falling edge after time zero, so the reset cannot be missed
        #10 arst_n_in = 1'h0;
        repeat (3) @(posedge clk_in);
        arst_n_in <= 1'h1;
        rdr(8'h04);
        chk("reset read", rv, 8'h02);
        t_cmds();
        t_reset();
        t_auto();
        t_refuse();
        t_tap();
        test_done();
    end
endmodule
